// >>> cohm_top.sv
// Coherent data cache and internal SRAM with snooping for the dma_requestor
`timescale 1ns/1ps
module cohm_top #(
  parameter int unsigned DC_LINES = cohm_pkg::DC_LINES_DEF,
  parameter int unsigned UM_WORDS = cohm_pkg::UM_WORDS_DEF
) (
  input  wire logic                        clk_sys_i,
  input  wire logic                        rst_i,
  input  wire logic                        cpu_req_i,
  input  wire logic                        cpu_we_i,
  input  wire logic                        cpu_cch_i,
  input  wire logic [cohm_pkg::ADDR_W-1:0] cpu_addr_i,
  input  wire logic [cohm_pkg::DATA_W-1:0] cpu_wdata_i,
  output logic                             cpu_ack_o,
  output logic      [cohm_pkg::DATA_W-1:0] cpu_rdata_o,
  input  wire logic                        pf_req_i,
  input  wire logic [cohm_pkg::ADDR_W-1:0] pf_addr_i,
  output logic                             pf_ack_o,
  output logic      [cohm_pkg::DATA_W-1:0] pf_rdata_o,
  input  wire logic                        dma_req_i,
  input  wire logic                        dma_we_i,
  input  wire logic [cohm_pkg::ADDR_W-1:0] dma_addr_i,
  input  wire logic [cohm_pkg::BE_W-1:0]   dma_be_i,
  input  wire logic [cohm_pkg::DATA_W-1:0] dma_wdata_i,
  output logic                             dma_ack_o,
  output logic      [cohm_pkg::DATA_W-1:0] dma_rdata_o,
  output logic                             ext_req_o,
  output logic                             ext_we_o,
  output logic      [cohm_pkg::ADDR_W-1:0] ext_addr_o,
  output logic      [cohm_pkg::BE_W-1:0]   ext_be_o,
  output logic      [cohm_pkg::DATA_W-1:0] ext_wdata_o,
  input  wire logic                        ext_ack_i,
  input  wire logic [cohm_pkg::DATA_W-1:0] ext_rdata_i,
  output logic                             snoop_inval_o,
  output logic                             snoop_wb_o
);

  import cohm_pkg::*;

  localparam int unsigned DC_IW  = $clog2(DC_LINES);
  localparam int unsigned UM_AW  = $clog2(UM_WORDS);
  localparam int unsigned TAG_W  = ADDR_W - WORD_LSB - DC_IW;
  localparam int unsigned HI_LSB = WORD_LSB + UM_AW;

  ////////////////////////////////////////////////////////////////////////////////
  // Elaboration checks

  generate
    if (DC_LINES < 2 || (DC_LINES & (DC_LINES - 1)) != 0) begin : g_bad_lines
      $error("DC_LINES must be a power of two, at least 2");
    end
    if (UM_WORDS < DC_LINES || (UM_WORDS & (UM_WORDS - 1)) != 0) begin : g_bad_words
      $error("UM_WORDS must be a power of two, not below DC_LINES");
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////////
  // Functions

  function automatic logic is_int(input logic [ADDR_W-1:0] a);
    is_int = (a[ADDR_W-1:HI_LSB] == INT_BASE[ADDR_W-1:HI_LSB]);
  endfunction : is_int

  // Byte lanes not enabled keep the older word
  function automatic logic [DATA_W-1:0] merge(input logic [DATA_W-1:0] old_w,
                                              input logic [DATA_W-1:0] new_w,
                                              input logic [BE_W-1:0]   be);
    logic [DATA_W-1:0] m;
    m = old_w;
    for (int b = 0; b < BE_W; b++) begin
      if (be[b]) begin
        m[8*b +: 8] = new_w[8*b +: 8];
      end
    end
    merge = m;
  endfunction : merge

  ////////////////////////////////////////////////////////////////////////////////
  // Storage and state

  logic [DATA_W-1:0] um_mem_r   [UM_WORDS];
  logic [DATA_W-1:0] dc_data_r  [DC_LINES];
  logic [TAG_W-1:0]  dc_tag_r   [DC_LINES];
  logic [DC_LINES-1:0] dc_valid_r;
  logic [DC_LINES-1:0] dc_dirty_r;

  cohm_state_e       state_r;
  cohm_state_e       state_nxt;
  cohm_src_e         src_r;
  logic              we_r;
  logic              cch_r;
  logic [ADDR_W-1:0] addr_r;
  logic [DATA_W-1:0] wdata_r;
  logic [BE_W-1:0]   be_r;

  logic              cpu_ack_r;
  logic              pf_ack_r;
  logic              dma_ack_r;
  logic [DATA_W-1:0] cpu_rdata_r;
  logic [DATA_W-1:0] pf_rdata_r;
  logic [DATA_W-1:0] dma_rdata_r;
  logic              ext_req_r;
  logic              ext_we_r;
  logic [ADDR_W-1:0] ext_addr_r;
  logic [BE_W-1:0]   ext_be_r;
  logic [DATA_W-1:0] ext_wdata_r;
  logic              snoop_inval_r;
  logic              snoop_wb_r;

  ////////////////////////////////////////////////////////////////////////////////
  // Request selection

  logic              gnt_dma_w;
  logic              gnt_cpu_w;
  logic              any_req_w;
  cohm_src_e         sel_src_w;
  logic              sel_we_w;
  logic              sel_cch_w;
  logic [ADDR_W-1:0] sel_addr_w;
  logic [DATA_W-1:0] sel_wdata_w;
  logic [BE_W-1:0]   sel_be_w;
  logic              sel_int_w;
  logic              take_w;

  // Fixed priority; one request at a time serializes every write
  assign gnt_dma_w   = dma_req_i;
  assign gnt_cpu_w   = !dma_req_i && cpu_req_i;
  assign any_req_w   = dma_req_i || cpu_req_i || pf_req_i;
  assign sel_src_w   = gnt_dma_w ? SRC_DMA : (gnt_cpu_w ? SRC_CPU : SRC_PF);
  assign sel_we_w    = gnt_dma_w ? dma_we_i : (gnt_cpu_w && cpu_we_i);
  assign sel_cch_w   = gnt_cpu_w ? cpu_cch_i : 1'b1;
  assign sel_addr_w  = gnt_dma_w ? dma_addr_i : (gnt_cpu_w ? cpu_addr_i : pf_addr_i);
  assign sel_wdata_w = gnt_dma_w ? dma_wdata_i : cpu_wdata_i;
  assign sel_be_w    = gnt_dma_w ? dma_be_i : BE_ALL;
  assign sel_int_w   = is_int(sel_addr_w);
  assign take_w      = (state_r == ST_IDLE) && any_req_w;

  ////////////////////////////////////////////////////////////////////////////////
  // Decoding of the held request

  logic [DC_IW-1:0]  dc_idx_w;
  logic [TAG_W-1:0]  dc_tag_w;
  logic              use_dc_w;
  logic              dc_hit_w;
  logic              victim_w;
  logic [ADDR_W-1:0] vict_addr_w;
  logic              shadow_hit_w;
  logic              snp_hit_w;
  logic              snp_wb_w;
  logic              acc_w;
  logic              evict_w;
  logic              fill_w;
  logic              done_w;

  assign dc_idx_w    = addr_r[WORD_LSB +: DC_IW];
  assign dc_tag_w    = addr_r[ADDR_W-1 -: TAG_W];
  // Program fetch and noncacheable data never consult the cache
  assign use_dc_w    = (src_r == SRC_CPU) && cch_r;
  assign dc_hit_w    = use_dc_w && dc_valid_r[dc_idx_w] &&
                       (dc_tag_r[dc_idx_w] == dc_tag_w);
  assign victim_w    = use_dc_w && !we_r && !dc_hit_w &&
                       dc_valid_r[dc_idx_w] && dc_dirty_r[dc_idx_w];
  assign vict_addr_w = {dc_tag_r[dc_idx_w], dc_idx_w, 2'h0};
  // Snoop issued only when the shadow says the line may be held
  assign snp_hit_w   = (state_r == ST_SNOOP) && shadow_hit_w;
  assign snp_wb_w    = snp_hit_w && dc_dirty_r[dc_idx_w];
  assign acc_w       = (state_r == ST_ACC) && !victim_w;
  assign evict_w     = (state_r == ST_EVICT);
  // Allocate on read miss only, never on write miss
  assign fill_w      = acc_w && use_dc_w && !we_r && !dc_hit_w;
  assign done_w      = acc_w || ((state_r == ST_EXT) && ext_ack_i);

  cohm_shadow #(
    .LINES (DC_LINES),
    .IW    (DC_IW),
    .TW    (TAG_W)
  ) u_shadow (
    .clk_sys_i (clk_sys_i),
    .rst_i     (rst_i),
    .idx_i     (dc_idx_w),
    .tag_i     (dc_tag_w),
    .fill_i    (fill_w),
    .inval_i   (snp_hit_w),
    .hit_o     (shadow_hit_w)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // SRAM write port

  logic              um_we_w;
  logic              wb_w;
  logic [ADDR_W-1:0] um_waddr_w;
  logic [UM_AW-1:0]  um_widx_w;
  logic [DATA_W-1:0] um_wsrc_w;
  logic [BE_W-1:0]   um_be_w;
  logic [DATA_W-1:0] um_wdata_w;
  logic [DATA_W-1:0] um_rdata_w;
  logic [DATA_W-1:0] rdata_nxt_w;

  assign wb_w       = snp_wb_w || evict_w;
  // Dirty line lands first; the DMA bytes merge over it next cycle
  assign um_we_w    = wb_w || (acc_w && we_r && !dc_hit_w);
  assign um_waddr_w = evict_w ? vict_addr_w : addr_r;
  assign um_widx_w  = um_waddr_w[WORD_LSB +: UM_AW];
  assign um_wsrc_w  = wb_w ? dc_data_r[dc_idx_w] : wdata_r;
  assign um_be_w    = wb_w ? BE_ALL : be_r;
  assign um_wdata_w = merge(um_mem_r[um_widx_w], um_wsrc_w, um_be_w);
  assign um_rdata_w = um_mem_r[addr_r[WORD_LSB +: UM_AW]];
  assign rdata_nxt_w = (state_r == ST_EXT) ? ext_rdata_i :
                       (dc_hit_w ? dc_data_r[dc_idx_w] : um_rdata_w);

  always_ff @(posedge clk_sys_i) begin
    if (um_we_w) begin
      um_mem_r[um_widx_w] <= um_wdata_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (any_req_w) begin
          if (!sel_int_w) begin
            state_nxt = ST_EXT;
          end else if (sel_src_w == SRC_DMA) begin
            state_nxt = ST_SNOOP;
          end else begin
            state_nxt = ST_ACC;
          end
        end
      end
      ST_SNOOP: begin
        state_nxt = ST_ACC;
      end
      ST_ACC: begin
        state_nxt = victim_w ? ST_EVICT : ST_DONE;
      end
      ST_EVICT: begin
        state_nxt = ST_ACC;
      end
      ST_EXT: begin
        if (ext_ack_i) begin
          state_nxt = ST_DONE;
        end
      end
      ST_DONE: begin
        state_nxt = ST_IDLE;
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      state_r <= ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      src_r   <= SRC_CPU;
      we_r    <= 1'b0;
      cch_r   <= 1'b0;
      addr_r  <= '0;
      wdata_r <= '0;
      be_r    <= '0;
    end else if (take_w) begin
      src_r   <= sel_src_w;
      we_r    <= sel_we_w;
      cch_r   <= sel_cch_w;
      addr_r  <= sel_addr_w;
      wdata_r <= sel_wdata_w;
      be_r    <= sel_be_w;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Data cache lines

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      dc_valid_r <= '0;
      dc_dirty_r <= '0;
    end else if (snp_hit_w) begin
      dc_valid_r[dc_idx_w] <= 1'b0;
      dc_dirty_r[dc_idx_w] <= 1'b0;
    end else if (evict_w) begin
      dc_dirty_r[dc_idx_w] <= 1'b0;
    end else if (acc_w && dc_hit_w && we_r) begin
      dc_dirty_r[dc_idx_w] <= 1'b1;
    end else if (fill_w) begin
      dc_valid_r[dc_idx_w] <= 1'b1;
      dc_dirty_r[dc_idx_w] <= 1'b0;
    end
  end

  // Tag and data need no reset; valid guards them
  always_ff @(posedge clk_sys_i) begin
    if (fill_w) begin
      dc_tag_r[dc_idx_w]  <= dc_tag_w;
      dc_data_r[dc_idx_w] <= um_rdata_w;
    end else if (acc_w && dc_hit_w && we_r) begin
      dc_data_r[dc_idx_w] <= wdata_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Answers to requestors

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cpu_ack_r     <= 1'b0;
      pf_ack_r      <= 1'b0;
      dma_ack_r     <= 1'b0;
      snoop_inval_r <= 1'b0;
      snoop_wb_r    <= 1'b0;
    end else begin
      cpu_ack_r     <= done_w && (src_r == SRC_CPU);
      pf_ack_r      <= done_w && (src_r == SRC_PF);
      dma_ack_r     <= done_w && (src_r == SRC_DMA);
      snoop_inval_r <= snp_hit_w;
      snoop_wb_r    <= snp_wb_w;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      cpu_rdata_r <= DATA_RST;
      pf_rdata_r  <= DATA_RST;
      dma_rdata_r <= DATA_RST;
    end else if (done_w && !we_r) begin
      if (src_r == SRC_CPU) begin
        cpu_rdata_r <= rdata_nxt_w;
      end
      if (src_r == SRC_PF) begin
        pf_rdata_r <= rdata_nxt_w;
      end
      if (src_r == SRC_DMA) begin
        dma_rdata_r <= rdata_nxt_w;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Forwarding of traffic outside the internal SRAM region

  // No copy is kept of anything sent out here
  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      ext_req_r   <= 1'b0;
      ext_we_r    <= 1'b0;
      ext_addr_r  <= '0;
      ext_be_r    <= '0;
      ext_wdata_r <= DATA_RST;
    end else if (take_w && !sel_int_w) begin
      ext_req_r   <= 1'b1;
      ext_we_r    <= sel_we_w;
      ext_addr_r  <= sel_addr_w;
      ext_be_r    <= sel_be_w;
      ext_wdata_r <= sel_wdata_w;
    end else if (ext_ack_i) begin
      ext_req_r   <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign cpu_ack_o     = cpu_ack_r;
  assign cpu_rdata_o   = cpu_rdata_r;
  assign pf_ack_o      = pf_ack_r;
  assign pf_rdata_o    = pf_rdata_r;
  assign dma_ack_o     = dma_ack_r;
  assign dma_rdata_o   = dma_rdata_r;
  assign ext_req_o     = ext_req_r;
  assign ext_we_o      = ext_we_r;
  assign ext_addr_o    = ext_addr_r;
  assign ext_be_o      = ext_be_r;
  assign ext_wdata_o   = ext_wdata_r;
  assign snoop_inval_o = snoop_inval_r;
  assign snoop_wb_o    = snoop_wb_r;

endmodule : cohm_top

// >>> cohm_pkg.sv
// Constants and types shared by the coherent two-level memory block
package cohm_pkg;

  localparam int unsigned ADDR_W       = 32;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned BE_W         = 4;
  localparam int unsigned WORD_LSB     = 2;
  localparam int unsigned DC_LINES_DEF = 16;
  localparam int unsigned UM_WORDS_DEF = 1024;
  // Upper address bits that select the internal SRAM region
  localparam logic [31:0] INT_BASE     = 32'h0000_0000;
  localparam logic [3:0]  BE_ALL       = 4'hf;
  localparam logic [31:0] DATA_RST     = 32'h0000_0000;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_SNOOP = 3'b001,
    ST_ACC   = 3'b010,
    ST_EVICT = 3'b011,
    ST_EXT   = 3'b100,
    ST_DONE  = 3'b101
  } cohm_state_e;

  typedef enum logic [1:0] {
    SRC_CPU = 2'b00,
    SRC_PF  = 2'b01,
    SRC_DMA = 2'b10
  } cohm_src_e;

endpackage : cohm_pkg

// >>> cohm_shadow.sv
// Shadow copy of the data cache tags, consulted before any snoop
`timescale 1ns/1ps
module cohm_shadow #(
  parameter int unsigned LINES = 16,
  parameter int unsigned IW    = 4,
  parameter int unsigned TW    = 26
) (
  input  wire logic          clk_sys_i,
  input  wire logic          rst_i,
  input  wire logic [IW-1:0] idx_i,
  input  wire logic [TW-1:0] tag_i,
  input  wire logic          fill_i,
  input  wire logic          inval_i,
  output logic               hit_o
);

  logic [TW-1:0]    tag_r [LINES];
  logic [LINES-1:0] valid_r;

  // Index width must cover every line exactly
  generate
    if (LINES != (1 << IW)) begin : g_bad_lines
      $error("LINES must equal two to the power IW");
    end
  endgenerate

  // Combinational answer so a snoop needs no extra cycle
  assign hit_o = valid_r[idx_i] && (tag_r[idx_i] == tag_i);

  always_ff @(posedge clk_sys_i) begin
    if (rst_i) begin
      valid_r <= '0;
    end else if (inval_i) begin
      valid_r[idx_i] <= 1'b0;
    end else if (fill_i) begin
      valid_r[idx_i] <= 1'b1;
    end
  end

  always_ff @(posedge clk_sys_i) begin
    if (fill_i) begin
      tag_r[idx_i] <= tag_i;
    end
  end

endmodule : cohm_shadow

// >>> cohm_props.sv
// Port-level concurrent checks for the coherent two-level memory block
`timescale 1ns/1ps
module cohm_props
  import cohm_pkg::*;
#(
  parameter int unsigned UM_WORDS = UM_WORDS_DEF
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_i,
  input wire logic              cpu_req_i,
  input wire logic              dma_req_i,
  input wire logic [ADDR_W-1:0] dma_addr_i,
  input wire logic              cpu_ack_o,
  input wire logic              pf_ack_o,
  input wire logic              dma_ack_o,
  input wire logic              ext_req_o,
  input wire logic              ext_ack_i,
  input wire logic [ADDR_W-1:0] ext_addr_o,
  input wire logic [BE_W-1:0]   ext_be_o,
  input wire logic              snoop_inval_o,
  input wire logic              snoop_wb_o
);
  localparam int unsigned SH = 2 + $clog2(UM_WORDS);
  logic dma_int;
  logic any_ack;
  assign dma_int = (dma_addr_i >> SH) == (INT_BASE >> SH);
  assign any_ack = cpu_ack_o | pf_ack_o | dma_ack_o;
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////////////
  one_ack_a: assert property ($onehot0({cpu_ack_o, pf_ack_o, dma_ack_o}))
    else $error("more than one requestor acknowledged");
  cpu_pulse_a: assert property (cpu_ack_o |=> !cpu_ack_o)
    else $error("cpu ack longer than one cycle");
  snoop_then_ack_a: assert property (snoop_inval_o |=> dma_ack_o)
    else $error("dma ack not one cycle after snoop");
  snoop_internal_a: assert property (snoop_inval_o |-> dma_req_i && dma_int)
    else $error("snoop without internal dma access");
  wb_needs_snoop_a: assert property (snoop_wb_o |-> snoop_inval_o)
    else $error("writeback pulse without snoop");
  ext_no_snoop_a: assert property (ext_req_o |-> !snoop_inval_o && !snoop_wb_o)
    else $error("snoop during forwarded access");
  ext_hold_a: assert property (ext_req_o && !ext_ack_i |=>
    ext_req_o && $stable(ext_addr_o))
    else $error("forwarded request changed before answer");
  ext_done_a: assert property (ext_req_o && ext_ack_i |=> !ext_req_o ##[0:1] any_ack)
    else $error("forwarded access not completed");
  cpu_full_be_a: assert property ($rose(ext_req_o) && $past(cpu_req_i && !dma_req_i)
    |-> ext_be_o == BE_ALL)
    else $error("cpu forwarded access without full byte enables");
endmodule : cohm_props

bind cohm_top cohm_props #(.UM_WORDS(UM_WORDS)) u_cohm_props (.clk_sys_i, .rst_i, .cpu_req_i,
  .dma_req_i, .dma_addr_i, .cpu_ack_o, .pf_ack_o, .dma_ack_o, .ext_req_o, .ext_ack_i,
  .ext_addr_o, .ext_be_o, .snoop_inval_o, .snoop_wb_o);

// >>> cohm_ext_model.sv
// Behavioural final target answering forwarded accesses
`timescale 1ns/1ps
module cohm_ext_model (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_i,
  input  wire logic        req_i,
  input  wire logic        we_i,
  input  wire logic [31:0] addr_i,
  input  wire logic [3:0]  be_i,
  input  wire logic [31:0] wdata_i,
  input  wire logic        slow_i,
  output logic             ack_o,
  output logic      [31:0] rdata_o
);
  logic [31:0] mem [logic [31:0]];
  logic [1:0]  cnt_r;
  // Read data toggles outside the answer cycle so stale capture shows up
  always @(posedge clk_sys_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      cnt_r <= 2'h0;
      rdata_o <= 32'h0;
    end else if (ack_o || !req_i) begin
      ack_o <= 1'b0;
      cnt_r <= 2'h0;
      rdata_o <= ~rdata_o;
    end else if (cnt_r >= (slow_i ? 2'h3 : 2'h0)) begin
      ack_o <= 1'b1;
      if (we_i) begin
        for (int b = 0; b < 4; b++) if (be_i[b]) mem[addr_i][8*b +: 8] = wdata_i[8*b +: 8];
      end else begin
        rdata_o <= mem.exists(addr_i) ? mem[addr_i] : ~rdata_o;
      end
    end else begin
      cnt_r <= cnt_r + 2'h1;
      rdata_o <= ~rdata_o;
    end
  end
endmodule : cohm_ext_model

// >>> cohm_top_bench.sv
// Self-checking bench for the coherent two-level memory block
`timescale 1ns/1ps
module cohm_top_bench;
  import cohm_pkg::*;
  logic        clk_sys_i, rst_i, ext_slow, cpu_req_i, cpu_we_i, cpu_cch_i, pf_req_i;
  logic        dma_req_i, dma_we_i, cpu_ack_o, pf_ack_o, dma_ack_o, ext_req_o, ext_we_o;
  logic        ext_ack_i, snoop_inval_o, snoop_wb_o, exp_si, exp_sw;
  logic [31:0] cpu_addr_i, cpu_wdata_i, pf_addr_i, dma_addr_i, dma_wdata_i, ext_rdata_i;
  logic [31:0] cpu_rdata_o, pf_rdata_o, dma_rdata_o, ext_addr_o, ext_wdata_o, exp_rd, r;
  logic [3:0]  dma_be_i, ext_be_o;
  logic [31:0] sm [64];
  logic [31:0] ext_ref [8];
  logic [31:0] cd [4];
  logic [5:0]  ctag [4];
  logic        cval [4];
  logic        cdirty [4];
  logic [31:0] seed = 32'h0000_4b5b;
  int          err_total, n_tests, cyc;

  cohm_top #(.DC_LINES(4), .UM_WORDS(64)) u_cohm_top (.clk_sys_i, .rst_i, .cpu_req_i,
    .cpu_we_i, .cpu_cch_i, .cpu_addr_i, .cpu_wdata_i, .cpu_ack_o, .cpu_rdata_o, .pf_req_i,
    .pf_addr_i, .pf_ack_o, .pf_rdata_o, .dma_req_i, .dma_we_i, .dma_addr_i, .dma_be_i,
    .dma_wdata_i, .dma_ack_o, .dma_rdata_o, .ext_req_o, .ext_we_o, .ext_addr_o, .ext_be_o,
    .ext_wdata_o, .ext_ack_i, .ext_rdata_i, .snoop_inval_o, .snoop_wb_o);
  cohm_ext_model u_cohm_ext_model (.clk_sys_i, .rst_i, .req_i(ext_req_o), .we_i(ext_we_o),
    .addr_i(ext_addr_o), .be_i(ext_be_o), .wdata_i(ext_wdata_o), .slow_i(ext_slow),
    .ack_o(ext_ack_i), .rdata_o(ext_rdata_i));
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd

  function automatic logic [31:0] merge(input logic [31:0] o, n, input logic [3:0] be);
    for (int b = 0; b < 4; b++) if (be[b]) o[8*b +: 8] = n[8*b +: 8];
    return o;
  endfunction : merge

  // Reference view: SRAM words plus one-word direct-mapped cache lines
  function automatic void predict(input cohm_src_e s, input logic we, cch,
                                  input logic [31:0] a, wd, input logic [3:0] be);
    logic [5:0] w;
    logic [1:0] l;
    logic       hit;
    w = a[7:2];
    l = w[1:0];
    hit = cval[l] && ctag[l] == w;
    {exp_si, exp_sw, exp_rd} = '0;
    if (a[31:8] != 24'h0) begin
      if (we) ext_ref[a[4:2]] = merge(ext_ref[a[4:2]], wd, (s == SRC_DMA) ? be : BE_ALL);
      else exp_rd = ext_ref[a[4:2]];
    end else if (s == SRC_DMA) begin
      if (hit) begin
        exp_si = 1'b1;
        exp_sw = cdirty[l];
        if (cdirty[l]) sm[w] = cd[l];
        cval[l] = 1'b0;
      end
      if (we) sm[w] = merge(sm[w], wd, be);
      else exp_rd = sm[w];
    end else if (s == SRC_PF || !cch) begin
      if (we) sm[w] = wd;
      else exp_rd = sm[w];
    end else if (we) begin
      if (hit) {cd[l], cdirty[l]} = {wd, 1'b1};
      else sm[w] = wd;
    end else if (!hit) begin
      if (cval[l] && cdirty[l]) sm[ctag[l]] = cd[l];
      {cval[l], cdirty[l], ctag[l], cd[l]} = {2'b10, w, sm[w]};
      exp_rd = cd[l];
    end else exp_rd = cd[l];
  endfunction : predict
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk_bit(input string nm, input logic e, input logic g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %b seen %b", nm, e, g);
    end
  endtask : chk_bit

  task automatic chk_data(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_total++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_data

  task automatic op(input cohm_src_e s, input logic we, cch, input logic [31:0] a, wd,
                    input logic [3:0] be);
    logic [31:0] got;
    logic        si, sw, ak;
    int          n;
    predict(s, we, cch, a, wd, be);
    {si, sw, ak, got, n} = '0;
    @(negedge clk_sys_i);
    case (s)
      SRC_CPU: {cpu_req_i, cpu_we_i, cpu_cch_i, cpu_addr_i, cpu_wdata_i} = {1'b1, we, cch, a, wd};
      SRC_PF:  {pf_req_i, pf_addr_i} = {1'b1, a};
      default: {dma_req_i, dma_we_i, dma_addr_i, dma_be_i, dma_wdata_i} = {1'b1, we, a, be, wd};
    endcase
    while (ak !== 1'b1 && n < 40) begin
      @(negedge clk_sys_i);
      n++;
      si |= snoop_inval_o;
      sw |= snoop_wb_o;
      ak = (s == SRC_CPU) ? cpu_ack_o : (s == SRC_PF) ? pf_ack_o : dma_ack_o;
      got = (s == SRC_CPU) ? cpu_rdata_o : (s == SRC_PF) ? pf_rdata_o : dma_rdata_o;
    end
    chk_bit("ack", 1'b1, ak);
    if (!we) chk_data("rdata", exp_rd, got);
    chk_bit("snoop_inval", exp_si, si);
    chk_bit("snoop_wb", exp_sw, sw);
    @(negedge clk_sys_i);
    {cpu_req_i, pf_req_i, dma_req_i} = '0;
  endtask : op

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  // Ceiling well above the few thousand cycles the sequence needs
  always @(posedge clk_sys_i) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      final_report();
    end
  end

  initial begin
    {rst_i, ext_slow} = 2'b10;
    {cpu_req_i, cpu_we_i, cpu_cch_i, pf_req_i, dma_req_i, dma_we_i, dma_be_i} = '0;
    {cpu_addr_i, cpu_wdata_i, pf_addr_i, dma_addr_i, dma_wdata_i} = '0;
    for (int i = 0; i < 4; i++) {cval[i], cdirty[i]} = 2'b00;
    repeat (4) @(negedge clk_sys_i);
    rst_i = 1'b0;
    for (int i = 0; i < 64; i++) op(SRC_DMA, 1'b1, 1'b0, 32'(i) << 2, rnd(), 4'hf);
    for (int i = 0; i < 8; i++)
      op(SRC_DMA, 1'b1, 1'b0, 32'h1000_0000 | (32'(i) << 2), rnd(), 4'hf);
    // Corners: dirty hit snooped by partial dma write, stale fetch, eviction
    op(SRC_CPU, 1'b0, 1'b1, 32'h14, 32'h0, 4'h0);
    op(SRC_CPU, 1'b1, 1'b1, 32'h14, rnd(), 4'h0);
    op(SRC_PF, 1'b0, 1'b0, 32'h14, 32'h0, 4'h0);
    op(SRC_DMA, 1'b1, 1'b0, 32'h14, rnd(), 4'h6);
    op(SRC_CPU, 1'b0, 1'b1, 32'h14, 32'h0, 4'h0);
    op(SRC_CPU, 1'b1, 1'b1, 32'h14, rnd(), 4'h0);
    op(SRC_DMA, 1'b0, 1'b0, 32'h14, 32'h0, 4'h0);
    op(SRC_CPU, 1'b1, 1'b1, 32'h24, rnd(), 4'h0);
    op(SRC_CPU, 1'b0, 1'b1, 32'h04, 32'h0, 4'h0);
    op(SRC_CPU, 1'b1, 1'b1, 32'h04, rnd(), 4'h0);
    op(SRC_CPU, 1'b0, 1'b1, 32'h24, 32'h0, 4'h0);
    op(SRC_DMA, 1'b0, 1'b0, 32'h04, 32'h0, 4'h0);
    // External pick uses bits apart from the write flag, so forwarded writes occur too
    for (int k = 0; k < 300; k++) begin
      r = rnd();
      @(negedge clk_sys_i);
      ext_slow = r[6];
      op(cohm_src_e'((r[1:0] == 2'b11) ? 2'b00 : r[1:0]), r[3] && r[1:0] != 2'b01, r[4],
         (r[19:17] == 3'h0) ? 32'h1000_0000 | {27'h0, r[10:8], 2'b00}
                            : {24'h0, (r[1:0] == 2'b10) ? r[11] : !r[4], 2'b00, r[10:8], 2'b00},
         rnd(), r[15:12]);
    end
    final_report();
  end
endmodule : cohm_top_bench
